// *** logic/decode_pkg.sv ***
// Constants, encodings and clock counts for the opcode subset decoder.
// Assumes one core clock; bytes arrive already fetched, in order.
package decode_pkg;

  localparam logic [7:0] OPC_ESCAPE    = 8'h0F;
  localparam logic [7:0] OPC_INVALID2  = 8'hFF;
  localparam logic [7:0] OPC_SIGN_EXT  = 8'hBE;
  localparam logic [7:0] OPC_ZERO_EXT  = 8'hB6;
  localparam logic [7:0] OPC_MUL_GRP   = 8'hF6;
  localparam logic [7:0] OPC_OR_RM     = 8'h08;
  localparam logic [7:0] OPC_OR_ACC    = 8'h0C;
  localparam logic [7:0] OPC_IMM_GRP   = 8'h80;
  localparam logic [7:0] OPC_POP_RM    = 8'h8F;
  localparam logic [7:0] OPC_POP_SHORT = 8'h58;
  localparam logic [7:0] OPC_POP_ES    = 8'h07;
  localparam logic [7:0] OPC_POP_SS    = 8'h17;
  localparam logic [7:0] OPC_POP_DS    = 8'h1F;
  localparam logic [7:0] OPC_POP_FS    = 8'hA1;
  localparam logic [7:0] OPC_POP_GS    = 8'hA9;
  localparam logic [7:0] OPC_POP_ALL   = 8'h61;
  localparam logic [7:0] OPC_POP_FLAGS = 8'h9D;

  localparam logic [7:0] MASK_W        = 8'hFE;
  localparam logic [7:0] MASK_DW       = 8'hFC;
  localparam logic [7:0] MASK_REG      = 8'hF8;
  localparam int         BIT_W         = 0;
  localparam int         BIT_S         = 1;

  localparam logic [2:0] REG_MUL       = 3'h4;
  localparam logic [2:0] REG_OR        = 3'h1;
  localparam logic [2:0] REG_POP       = 3'h0;

  localparam logic [2:0] BYTES_BYTE    = 3'h1;
  localparam logic [2:0] BYTES_WORD    = 3'h2;
  localparam logic [2:0] BYTES_DWORD   = 3'h4;

  localparam int         CLK_W         = 7;
  localparam logic [CLK_W-1:0] CLK_ONE        = 7'h01;
  localparam logic [CLK_W-1:0] CLK_MUL_NARROW = 7'h04;
  localparam logic [CLK_W-1:0] CLK_MUL_DWORD  = 7'h0A;
  localparam logic [CLK_W-1:0] CLK_INV_REAL   = 7'h01;
  localparam logic [CLK_W-1:0] CLK_INV_PROT   = 7'h08;
  localparam logic [CLK_W-1:0] CLK_INV_PMAX   = 7'h7D;
  localparam logic [CLK_W-1:0] CLK_POPSEG_PROT = 7'h03;
  localparam logic [CLK_W-1:0] CLK_POP_ALL    = 7'h06;
  localparam logic [CLK_W-1:0] CLK_POP_FLAGS  = 7'h09;

  // Flag vector order: OF DF IF TF SF ZF AF PF CF, OF in bit 8
  localparam logic [8:0] FL_NONE       = 9'h000;
  localparam logic [8:0] FL_OR_WRITE   = 9'h01A;
  localparam logic [8:0] FL_OR_ZERO    = 9'h101;
  localparam logic [8:0] FL_OR_UNDEF   = 9'h004;
  localparam logic [8:0] FL_MUL_WRITE  = 9'h101;
  localparam logic [8:0] FL_MUL_UNDEF  = 9'h01E;
  localparam logic [8:0] FL_ALL        = 9'h1FF;

  typedef enum logic [3:0] {
    OPK_NONE, OPK_SIGN_EXT, OPK_ZERO_EXT, OPK_MUL, OPK_INVALID,
    OPK_OR, OPK_POP, OPK_POP_SEG, OPK_POP_ALL, OPK_POP_FLAGS, OPK_UNKNOWN
  } op_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ESC, ST_MODRM, ST_IMM, ST_EXEC
  } dec_state_t;

endpackage

// *** logic/exec_timer.sv ***
// Down counter that paces the execute phase of one instruction.
// Assumes load and clkEn come from logic on the same clock.
`timescale 1ns/1ps
module exec_timer
  import decode_pkg::*;
#(
  parameter int W = CLK_W
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         clkEn,
  input  wire logic         load,
  input  wire logic [W-1:0] loadValue,
  output logic              expire
);

  logic [W-1:0] remain_ff;
  logic [W-1:0] nxt_remain;

  always_comb begin
    nxt_remain = remain_ff;
    if (load) begin
      nxt_remain = loadValue;
    end else if (remain_ff != '0) begin
      nxt_remain = remain_ff - W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      remain_ff <= '0;
    end else if (clkEn) begin
      remain_ff <= nxt_remain;
    end
  end

  // Last execute cycle when one clock remains
  assign expire = (remain_ff == W'(1));

endmodule

// *** logic/x86_subset_decoder.sv ***
// Decoder and clock pacing for one slice of the x86 integer opcodes.
// Assumes bytes come in order from a fetch stage on the same clock;
// displacement and SIB bytes are consumed elsewhere.
// What this block does
// - Sign-extend move: escape, B[111w], modrm; 1 clock
// - Multiply reg 100: 4/4/10 clocks, OF CF
// - Escape FF: invalid opcode, 1 clock real, 8 protected
// - OR forms decode and finish in 1 clock
// - OR: OF CF zero, SZP set, AF undefined
// - Pops 1 clock; segment pops 3 protected
// - Opcode 61 pops all registers, 6 clocks
// - Opcode 9D pops flags, nine flags, 9 clocks
// - Full immediate sized 8, 16 or 32 bits
`timescale 1ns/1ps
module x86_subset_decoder
  import decode_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       clkEn,
  input  wire logic       protMode,
  input  wire logic       opSize32,
  input  wire logic       byteValid,
  input  wire logic [7:0] byteIn,
  output logic            byteReady,
  output logic            done,
  output logic            invalidOp,
  output logic            unknownOp,
  output op_kind_t        opKind,
  output logic [2:0]      operandBytes,
  output logic [7:0]      modrm,
  output logic [31:0]     immData,
  output logic [8:0]      flagWrite,
  output logic [8:0]      flagZero,
  output logic [8:0]      flagUndef
);

  dec_state_t  state_ff,   nxt_state;
  op_kind_t    kind_ff,    nxt_kind;
  logic [2:0]  opBytes_ff, nxt_opBytes;
  logic [7:0]  modrm_ff,   nxt_modrm;
  logic [31:0] imm_ff,     nxt_imm;
  logic [2:0]  immLeft_ff, nxt_immLeft;
  logic [2:0]  immIdx_ff,  nxt_immIdx;
  logic        needImm_ff, nxt_needImm;
  logic        immSext_ff, nxt_immSext;
  logic        regChk_ff,  nxt_regChk;
  logic [2:0]  regWant_ff, nxt_regWant;
  logic        done_ff,    nxt_done;
  logic        inv_ff,     nxt_inv;
  logic        unk_ff,     nxt_unk;
  logic [8:0]  fw_ff,      nxt_fw;
  logic [8:0]  fz_ff,      nxt_fz;
  logic [8:0]  fu_ff,      nxt_fu;

  logic             take;
  logic             load;
  logic [CLK_W-1:0] loadVal;
  logic             expire;
  logic [2:0]       fullBytes;
  logic [2:0]       wBytes;

  function automatic logic [CLK_W-1:0] exec_clocks(
    input op_kind_t k, input logic [2:0] nb, input logic pm);
    case (k)
      OPK_MUL:       exec_clocks = (nb == BYTES_DWORD) ?
                                   CLK_MUL_DWORD : CLK_MUL_NARROW;
      OPK_INVALID:   exec_clocks = pm ? CLK_INV_PROT : CLK_INV_REAL;
      OPK_POP_SEG:   exec_clocks = pm ? CLK_POPSEG_PROT : CLK_ONE;
      OPK_POP_ALL:   exec_clocks = CLK_POP_ALL;
      OPK_POP_FLAGS: exec_clocks = CLK_POP_FLAGS;
      default:       exec_clocks = CLK_ONE;
    endcase
  endfunction

  exec_timer #(
    .W (CLK_W)
  ) u_timer (
    .clk       (clk),
    .reset     (reset),
    .clkEn     (clkEn),
    .load      (load),
    .loadValue (loadVal),
    .expire    (expire)
  );

  assign byteReady = (state_ff != ST_EXEC);
  assign take      = byteValid && byteReady && clkEn;
  assign fullBytes = opSize32 ? BYTES_DWORD : BYTES_WORD;
  assign wBytes    = byteIn[BIT_W] ? fullBytes : BYTES_BYTE;

  always_comb begin
    nxt_state   = state_ff;
    nxt_kind    = kind_ff;
    nxt_opBytes = opBytes_ff;
    nxt_modrm   = modrm_ff;
    nxt_imm     = imm_ff;
    nxt_immLeft = immLeft_ff;
    nxt_immIdx  = immIdx_ff;
    nxt_needImm = needImm_ff;
    nxt_immSext = immSext_ff;
    nxt_regChk  = regChk_ff;
    nxt_regWant = regWant_ff;
    nxt_done    = 1'b0;
    nxt_inv     = 1'b0;
    nxt_unk     = 1'b0;
    nxt_fw      = fw_ff;
    nxt_fz      = fz_ff;
    nxt_fu      = fu_ff;
    load        = 1'b0;
    loadVal     = CLK_ONE;
    case (state_ff)
      ST_IDLE: begin
        if (take) begin
          nxt_imm     = '0;
          nxt_immIdx  = '0;
          nxt_needImm = 1'b0;
          nxt_immSext = 1'b0;
          nxt_regChk  = 1'b0;
          nxt_opBytes = wBytes;
          nxt_immLeft = wBytes;
          nxt_state   = ST_MODRM;
          if (byteIn == OPC_ESCAPE) begin
            nxt_state = ST_ESC;
          end else if ((byteIn & MASK_DW) == OPC_OR_RM) begin
            nxt_kind = OPK_OR;
          end else if ((byteIn & MASK_W) == OPC_OR_ACC) begin
            nxt_kind    = OPK_OR;
            nxt_needImm = 1'b1;
            nxt_state   = ST_IMM;
          end else if ((byteIn & MASK_DW) == OPC_IMM_GRP) begin
            nxt_kind    = OPK_OR;
            nxt_needImm = 1'b1;
            nxt_regChk  = 1'b1;
            nxt_regWant = REG_OR;
            // Short sign-extended immediate when s and w are both set
            nxt_immSext = byteIn[BIT_S] && byteIn[BIT_W];
            if (byteIn[BIT_S]) begin
              nxt_immLeft = BYTES_BYTE;
            end
          end else if ((byteIn & MASK_W) == OPC_MUL_GRP) begin
            nxt_kind    = OPK_MUL;
            nxt_regChk  = 1'b1;
            nxt_regWant = REG_MUL;
          end else if (byteIn == OPC_POP_RM) begin
            nxt_kind    = OPK_POP;
            nxt_regChk  = 1'b1;
            nxt_regWant = REG_POP;
            nxt_opBytes = fullBytes;
          end else if ((byteIn & MASK_REG) == OPC_POP_SHORT) begin
            nxt_kind    = OPK_POP;
            nxt_opBytes = fullBytes;
            nxt_state   = ST_EXEC;
          end else if (byteIn == OPC_POP_ES || byteIn == OPC_POP_SS ||
                       byteIn == OPC_POP_DS) begin
            nxt_kind  = OPK_POP_SEG;
            nxt_state = ST_EXEC;
          end else if (byteIn == OPC_POP_ALL) begin
            nxt_kind  = OPK_POP_ALL;
            nxt_state = ST_EXEC;
          end else if (byteIn == OPC_POP_FLAGS) begin
            nxt_kind  = OPK_POP_FLAGS;
            nxt_state = ST_EXEC;
          end else begin
            nxt_kind  = OPK_UNKNOWN;
            nxt_unk   = 1'b1;
            nxt_state = ST_IDLE;
          end
        end
      end
      ST_ESC: begin
        if (take) begin
          nxt_opBytes = wBytes;
          nxt_state   = ST_MODRM;
          if ((byteIn & MASK_W) == OPC_SIGN_EXT) begin
            nxt_kind = OPK_SIGN_EXT;
          end else if ((byteIn & MASK_W) == OPC_ZERO_EXT) begin
            nxt_kind = OPK_ZERO_EXT;
          end else if (byteIn == OPC_INVALID2) begin
            nxt_kind  = OPK_INVALID;
            nxt_state = ST_EXEC;
          end else if (byteIn == OPC_POP_FS || byteIn == OPC_POP_GS) begin
            nxt_kind  = OPK_POP_SEG;
            nxt_state = ST_EXEC;
          end else begin
            nxt_kind  = OPK_UNKNOWN;
            nxt_unk   = 1'b1;
            nxt_state = ST_IDLE;
          end
        end
      end
      ST_MODRM: begin
        if (take) begin
          nxt_modrm = byteIn;
          if (regChk_ff && byteIn[5:3] != regWant_ff) begin
            nxt_kind  = OPK_UNKNOWN;
            nxt_unk   = 1'b1;
            nxt_state = ST_IDLE;
          end else if (needImm_ff) begin
            nxt_state = ST_IMM;
          end else begin
            nxt_state = ST_EXEC;
          end
        end
      end
      ST_IMM: begin
        if (take) begin
          nxt_imm[{immIdx_ff[1:0], 3'h0} +: 8] = byteIn;
          nxt_immIdx  = immIdx_ff + 3'h1;
          nxt_immLeft = immLeft_ff - 3'h1;
          if (immLeft_ff == BYTES_BYTE) begin
            nxt_state = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        if (expire) begin
          nxt_state = ST_IDLE;
          nxt_done  = 1'b1;
          nxt_inv   = (kind_ff == OPK_INVALID);
          nxt_fw    = FL_NONE;
          nxt_fz    = FL_NONE;
          nxt_fu    = FL_NONE;
          case (kind_ff)
            OPK_OR: begin
              nxt_fw = FL_OR_WRITE;
              nxt_fz = FL_OR_ZERO;
              nxt_fu = FL_OR_UNDEF;
            end
            OPK_MUL: begin
              nxt_fw = FL_MUL_WRITE;
              nxt_fu = FL_MUL_UNDEF;
            end
            OPK_POP_FLAGS: nxt_fw = FL_ALL;
            default:       nxt_fw = FL_NONE;
          endcase
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    // Timer armed on the way into execute, so the count is exact
    if (nxt_state == ST_EXEC && state_ff != ST_EXEC) begin
      load    = 1'b1;
      loadVal = exec_clocks(nxt_kind, nxt_opBytes, protMode);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff   <= ST_IDLE;
      kind_ff    <= OPK_NONE;
      opBytes_ff <= BYTES_BYTE;
      modrm_ff   <= '0;
      imm_ff     <= '0;
      immLeft_ff <= '0;
      immIdx_ff  <= '0;
      needImm_ff <= 1'b0;
      immSext_ff <= 1'b0;
      regChk_ff  <= 1'b0;
      regWant_ff <= '0;
      done_ff    <= 1'b0;
      inv_ff     <= 1'b0;
      unk_ff     <= 1'b0;
      fw_ff      <= FL_NONE;
      fz_ff      <= FL_NONE;
      fu_ff      <= FL_NONE;
    end else if (clkEn) begin
      state_ff   <= nxt_state;
      kind_ff    <= nxt_kind;
      opBytes_ff <= nxt_opBytes;
      modrm_ff   <= nxt_modrm;
      imm_ff     <= nxt_imm;
      immLeft_ff <= nxt_immLeft;
      immIdx_ff  <= nxt_immIdx;
      needImm_ff <= nxt_needImm;
      immSext_ff <= nxt_immSext;
      regChk_ff  <= nxt_regChk;
      regWant_ff <= nxt_regWant;
      done_ff    <= nxt_done;
      inv_ff     <= nxt_inv;
      unk_ff     <= nxt_unk;
      fw_ff      <= nxt_fw;
      fz_ff      <= nxt_fz;
      fu_ff      <= nxt_fu;
    end
  end

  assign done         = done_ff;
  assign invalidOp    = inv_ff;
  assign unknownOp    = unk_ff;
  assign opKind       = kind_ff;
  assign operandBytes = opBytes_ff;
  assign modrm        = modrm_ff;
  assign immData      = imm_ff;
  assign flagWrite    = fw_ff;
  assign flagZero     = fz_ff;
  assign flagUndef    = fu_ff;

  // Execute-phase length, held for the cycle of done
  logic [CLK_W-1:0] lenCnt_ff;
  always_ff @(posedge clk) begin
    if (reset) begin
      lenCnt_ff <= '0;
    end else if (clkEn) begin
      lenCnt_ff <= (state_ff == ST_EXEC) ? lenCnt_ff + CLK_ONE : '0;
    end
  end

  default clocking cb @(posedge clk iff clkEn); endclocking
  default disable iff (reset);

  sequence s_escape;
    take && state_ff == ST_IDLE && byteIn == OPC_ESCAPE;
  endsequence
  sequence s_invalid_byte;
    take && byteIn == OPC_INVALID2;
  endsequence

  a_sign_ext_time: assert property (done && opKind == OPK_SIGN_EXT
    |-> lenCnt_ff == CLK_ONE) else $error("sign extend time");
  a_zero_ext_time: assert property (done && opKind == OPK_ZERO_EXT
    |-> lenCnt_ff == CLK_ONE) else $error("zero extend time");
  a_mul_time_flags: assert property (done && opKind == OPK_MUL
    |-> lenCnt_ff == ((operandBytes == BYTES_DWORD) ? CLK_MUL_DWORD :
        CLK_MUL_NARROW) && flagWrite == FL_MUL_WRITE)
    else $error("multiply timing or flags");
  a_invalid_raise: assert property (s_escape ##1 s_invalid_byte
    |-> ##[1:126] invalidOp) else $error("invalid opcode late");
  a_or_time: assert property (done && opKind == OPK_OR
    |-> lenCnt_ff == CLK_ONE) else $error("or time");
  a_or_flags: assert property (done && opKind == OPK_OR
    |-> flagZero == FL_OR_ZERO && flagUndef == FL_OR_UNDEF &&
        flagWrite == FL_OR_WRITE) else $error("or flags");
  a_pop_seg_prot: assert property (done && opKind == OPK_POP_SEG &&
    $past(protMode) |-> lenCnt_ff == CLK_POPSEG_PROT)
    else $error("segment pop time");
  a_pop_all_time: assert property (done && opKind == OPK_POP_ALL
    |-> lenCnt_ff == CLK_POP_ALL) else $error("pop all time");
  a_pop_flags_all: assert property (done && opKind == OPK_POP_FLAGS
    |-> lenCnt_ff == CLK_POP_FLAGS && flagWrite == FL_ALL)
    else $error("pop flags");
  a_imm_size: assert property (done && needImm_ff && !immSext_ff &&
    opKind == OPK_OR && immIdx_ff != BYTES_BYTE
    |-> immIdx_ff == operandBytes) else $error("immediate size");

endmodule

// *** verification/test_x86_subset_decoder.sv ***
// Self-checking bench for the opcode subset decoder.
// Drives the byte stream itself; no fetch stage or memory model exists.
`timescale 1ns/1ps
module test_x86_subset_decoder
  import decode_pkg::*;
;
  typedef logic [7:0] bq_t[$];

  logic        clk;
  logic        reset;
  logic        clkEn;
  logic        protMode;
  logic        opSize32;
  logic        byteValid;
  logic [7:0]  byteIn;
  logic        byteReady;
  logic        done;
  logic        invalidOp;
  logic        unknownOp;
  op_kind_t    opKind;
  logic [2:0]  operandBytes;
  logic [7:0]  modrm;
  logic [31:0] immData;
  logic [8:0]  flagWrite;
  logic [8:0]  flagZero;
  logic [8:0]  flagUndef;
  int          fails;
  int          comparisons;

  x86_subset_decoder i_dut (
    .clk          (clk),
    .reset        (reset),
    .clkEn        (clkEn),
    .protMode     (protMode),
    .opSize32     (opSize32),
    .byteValid    (byteValid),
    .byteIn       (byteIn),
    .byteReady    (byteReady),
    .done         (done),
    .invalidOp    (invalidOp),
    .unknownOp    (unknownOp),
    .opKind       (opKind),
    .operandBytes (operandBytes),
    .modrm        (modrm),
    .immData      (immData),
    .flagWrite    (flagWrite),
    .flagZero     (flagZero),
    .flagUndef    (flagUndef)
  );

  always #10 clk = ~clk;

  task automatic finish_test;
    $display("Mismatches %0d, comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic chk_kind(input op_kind_t got, input op_kind_t exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t kind got %s expected %s", $time, got.name(),
               exp.name());
    end
  endtask

  // Bytes only offered outside execute, while byteReady is high, so all are taken
  task automatic send(input bq_t bq);
    foreach (bq[i]) begin
      byteIn = bq[i];
      byteValid = 1'b1;
      @(posedge clk);
      #1;
    end
    byteValid = 1'b0;
  endtask

  // Execute length shows as cycles with byteReady low before done
  task automatic wait_done(input int n);
    int cnt;
    int guard;
    cnt = 0;
    guard = 0;
    while (done !== 1'b1 && guard < 300) begin
      if (byteReady === 1'b0) cnt++;
      guard++;
      @(posedge clk);
      #1;
    end
    chk(done, 1'b1, "done");
    chk(cnt, n, "clocks");
  endtask

  // nb of zero skips the size check
  task automatic op(input bq_t bq, input logic pm, input logic sz,
                    input int n, input op_kind_t k, input logic [2:0] nb);
    protMode = pm;
    opSize32 = sz;
    send(bq);
    wait_done(n);
    chk_kind(opKind, k);
    if (nb != 3'h0) chk(operandBytes, nb, "size");
  endtask

  task automatic flags(input logic [8:0] w, input logic [8:0] z,
                       input logic [8:0] u);
    chk(flagWrite, w, "flag write");
    chk(flagZero, z, "flag zero");
    chk(flagUndef, u, "flag undef");
  endtask

  task automatic unk(input bq_t bq);
    send(bq);
    chk(unknownOp, 1'b1, "unknown");
    chk(done, 1'b0, "done on unknown");
    @(posedge clk);
    #1;
    chk(unknownOp, 1'b0, "unknown pulse");
  endtask

  task automatic t_movx;
    op('{OPC_ESCAPE, OPC_SIGN_EXT, 8'hC1}, 1'b0, 1'b1, 1, OPK_SIGN_EXT,
       BYTES_BYTE);
    chk(modrm, 8'hC1, "modrm");
    // Bit w set gives the full operand size, 4 bytes under opSize32
    op('{OPC_ESCAPE, OPC_SIGN_EXT | 8'h01, 8'hCA}, 1'b1, 1'b1, 1,
       OPK_SIGN_EXT, BYTES_DWORD);
    op('{OPC_ESCAPE, OPC_ZERO_EXT, 8'hD3}, 1'b1, 1'b0, 1, OPK_ZERO_EXT,
       BYTES_BYTE);
    op('{OPC_ESCAPE, OPC_ZERO_EXT | 8'h01, 8'hC0}, 1'b0, 1'b0, 1,
       OPK_ZERO_EXT, BYTES_WORD);
  endtask

  task automatic t_mul;
    op('{OPC_MUL_GRP, 8'hE1}, 1'b0, 1'b0, 4, OPK_MUL,
       BYTES_BYTE);
    flags(FL_MUL_WRITE, FL_NONE, FL_MUL_UNDEF);
    chk(invalidOp, 1'b0, "no invalid");
    op('{OPC_MUL_GRP | 8'h01, 8'hE2}, 1'b1, 1'b0, 4, OPK_MUL,
       BYTES_WORD);
    op('{OPC_MUL_GRP | 8'h01, 8'hE3}, 1'b0, 1'b1, 10, OPK_MUL,
       BYTES_DWORD);
  endtask

  task automatic t_invalid;
    op('{OPC_ESCAPE, OPC_INVALID2}, 1'b0, 1'b0, 1, OPK_INVALID,
       3'h0);
    chk(invalidOp, 1'b1, "invalid");
    op('{OPC_ESCAPE, OPC_INVALID2}, 1'b1, 1'b0, 8, OPK_INVALID,
       3'h0);
    chk(invalidOp, 1'b1, "invalid");
  endtask

  task automatic t_or;
    logic [7:0] b;
    for (int r = 0; r < 4; r++) begin
      b = OPC_OR_RM | 8'(r);
      op('{b, 8'hC0}, 1'b0, 1'b1, 1, OPK_OR,
         b[0] ? BYTES_DWORD : BYTES_BYTE);
      flags(FL_OR_WRITE, FL_OR_ZERO, FL_OR_UNDEF);
    end
    op('{OPC_OR_ACC, 8'h5A}, 1'b0, 1'b1, 1, OPK_OR,
       BYTES_BYTE);
    chk(immData[7:0], 8'h5A, "imm8");
    op('{OPC_OR_ACC | 8'h01, 8'h34, 8'h12}, 1'b0, 1'b0, 1, OPK_OR,
       BYTES_WORD);
    chk(immData[15:0], 16'h1234, "imm16");
    op('{OPC_OR_ACC | 8'h01, 8'h78, 8'h56, 8'h34, 8'h12}, 1'b1, 1'b1, 1,
       OPK_OR, BYTES_DWORD);
    chk(immData, 32'h1234_5678, "imm32");
    op('{OPC_IMM_GRP, 8'hC9, 8'h7F}, 1'b1, 1'b1, 1, OPK_OR,
       BYTES_BYTE);
    chk(immData[7:0], 8'h7F, "grp imm8");
    op('{OPC_IMM_GRP | 8'h03, 8'hCA, 8'hF0}, 1'b0, 1'b1, 1, OPK_OR,
       BYTES_DWORD);
    chk(immData[7:0], 8'hF0, "sign imm");
    op('{OPC_IMM_GRP | 8'h01, 8'hC8, 8'hEF, 8'hBE}, 1'b0, 1'b0, 1, OPK_OR,
       BYTES_WORD);
    chk(immData[15:0], 16'hBEEF, "grp imm16");
  endtask

  task automatic t_pop;
    bq_t segs[5];
    segs = '{'{OPC_POP_ES}, '{OPC_POP_SS}, '{OPC_POP_DS},
             '{OPC_ESCAPE, OPC_POP_FS}, '{OPC_ESCAPE, OPC_POP_GS}};
    op('{OPC_POP_RM, 8'hC0}, 1'b0, 1'b0, 1, OPK_POP,
       BYTES_WORD);
    for (int r = 0; r < 8; r++) begin
      op('{OPC_POP_SHORT | 8'(r)}, 1'b1, 1'b1, 1, OPK_POP,
         BYTES_DWORD);
    end
    for (int pm = 0; pm < 2; pm++) begin
      foreach (segs[i]) begin
        op(segs[i], pm[0], 1'b0, pm ? 3 : 1, OPK_POP_SEG,
           3'h0);
      end
      op('{OPC_POP_ALL}, pm[0], 1'b0, 6, OPK_POP_ALL, 3'h0);
      op('{OPC_POP_FLAGS}, pm[0], 1'b1, 9, OPK_POP_FLAGS,
         3'h0);
      chk(flagWrite, FL_ALL, "flags all");
    end
  endtask

  // Stalled enable must stretch execute, not shorten it
  task automatic t_freeze;
    protMode = 1'b0;
    send('{OPC_POP_FLAGS});
    clkEn = 1'b0;
    repeat (3) begin
      @(posedge clk);
      #1;
    end
    chk(byteReady, 1'b0, "frozen ready");
    chk(done, 1'b0, "frozen done");
    clkEn = 1'b1;
    wait_done(9);
  endtask

  task automatic t_unknown;
    unk('{OPC_MUL_GRP, 8'hD8});
    unk('{OPC_POP_RM, 8'hC8});
    unk('{OPC_IMM_GRP, 8'hE0});
    unk('{8'h90});
  endtask

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    clkEn = 1'b1;
    protMode = 1'b0;
    opSize32 = 1'b0;
    byteValid = 1'b0;
    byteIn = 8'h00;
    fails = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    #1;
    chk(done, 1'b0, "reset done");
    chk_kind(opKind, OPK_NONE);
    chk(operandBytes, 3'h1, "reset size");
    chk(flagWrite, 9'h000, "reset flags");
    chk(byteReady, 1'b1, "reset ready");
    reset = 1'b0;
    t_movx;
    t_mul;
    t_invalid;
    t_or;
    t_pop;
    t_freeze;
    t_unknown;
    finish_test;
  end

  // Whole run is a few hundred cycles; far margin before declaring a hang
  initial begin
    #100000;
    fails++;
    finish_test;
  end
endmodule
